// [hw/mrs_reset_defs.vh]
// register indices, reset values and timing counts of the reset sequencer
`ifndef MRS_RESET_DEFS_VH
`define MRS_RESET_DEFS_VH
// register indices; byte address is index times four
`define MRS_IX_FLAGS 6'd0
`define MRS_IX_PULLH 6'd1
`define MRS_IX_PULLL 6'd2
`define MRS_IX_CLKCTL 6'd3
`define MRS_IX_OSCMODE 6'd4
`define MRS_IX_STABSEL 6'd5
`define MRS_IX_TMRCLK 6'd6
`define MRS_IX_MEMMAP 6'd7
`define MRS_IX_WDCLK 6'd8
`define MRS_IX_WDMODE 6'd9
`define MRS_IX_CSMODE 6'd10
`define MRS_IX_ASMODE 6'd11
`define MRS_IX_ASFLAGS 6'd12
`define MRS_IX_BAUD 6'd13
`define MRS_IX_TXSHIFT 6'd14
`define MRS_IX_ADMODE 6'd15
`define MRS_IX_ADINSEL 6'd16
`define MRS_IX_IRQREQ 6'd17
`define MRS_IX_IRQMASK 6'd18
`define MRS_IX_IRQPRIO 6'd19
`define MRS_IX_IRQEDGE 6'd20
`define MRS_IX_TMR_BASE 6'd21
`define MRS_IX_LATCH_BASE 6'd29
`define MRS_IX_DIR_BASE 6'd35
`define MRS_IX_STATUS 6'd41
// reset values
`define MRS_RV_FLAGS 8'h02
`define MRS_RV_CLKCTL 8'h04
`define MRS_RV_STABSEL 8'h04
`define MRS_RV_MEMMAP 8'h46
`define MRS_RV_TXSHIFT 8'hFF
`define MRS_RV_ADMODE 8'h01
`define MRS_RV_IRQMASK 8'hFF
`define MRS_RV_IRQPRIO 8'hFF
`define MRS_RV_DIR 8'hFF
`define MRS_RV_ZERO 8'h00
// memory map settings
`define MRS_MAP_LARGE 8'h46
`define MRS_MAP_SMALL 8'h82
`define MRS_MAP_MID 8'h64
// reset vector, low byte first
`define MRS_VEC_ADDR_LO 16'h0000
`define MRS_VEC_ADDR_HI 16'h0001
// timing
`define MRS_STAB_OSC_PERIODS 131072
`define MRS_OSC_PER_CLK 1
`define MRS_WDT_HOLD_CYCLES 4'd4
`endif

// [hw/mrs_reset_seq.v]
// reset sequencer: reset sources, stabilization wait, reset register file
//
// Summary of operation
// - pin low or watchdog overflow give one common reset, same effect.
// - after the wait, program counter loads from vector bytes 0000H/0001H.
// - all pins float during reset and the stabilization wait.
// - pin high releases reset, then 2^17 oscillator periods before running.
// - watchdog reset self-releases and then takes the same wait.
// - main oscillator stops while the reset pin is low.
// - reset out of stop keeps stop contents while held; ports float.
// - during reset and wait only the program counter is undefined.
// - stack, RAM, general registers, converter result untouched; RAM kept, but ram_retain_o is raised only for a reset out of stop.
// - reset sets the flags word to 02H.
// - port latches clear to 00H, direction registers set to FFH.
// - clock control 04H, stabilization select 04H, pull-up, osc mode 00H.
// - both event counters and watchdog clock and mode registers clear.
// - serial mode, status and baud clear; transmit shift loads FFH.
// - converter mode 01H, converter input select 00H.
// - irq flags and edge mode clear; mask and priority set FFH.
// - reset loads the memory map register with 46H.
// - reset map gives 24 Kbytes ROM and 512 bytes RAM.
// - memory map register is written only as a whole byte.
// - 82H or 64H shrink the map to the smaller variants.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_reset_defs.vh"

module mrs_reset_seq #(
  parameter STAB_CYCLES = `MRS_STAB_OSC_PERIODS * `MRS_OSC_PER_CLK,
  parameter NPORT = 6,
  parameter NREG = 42
) (
  input wire clk_i,
  input wire rst_i,
  input wire ext_reset_n_i,
  input wire wdt_overflow_i,
  input wire stop_mode_i,
  input wire [7:0] vec_lo_i,
  input wire [7:0] vec_hi_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg core_reset_o,
  output reg pin_hiz_o,
  output reg osc_stop_o,
  output reg ram_retain_o,
  output reg cpu_run_o,
  output reg [15:0] vec_addr_o,
  output reg [15:0] instr_pointer_o,
  output reg [5:0] rom_kbytes_o,
  output reg [9:0] ram_bytes_o,
  output reg [8*NPORT-1:0] port_out_o,
  output reg [8*NPORT-1:0] port_oe_o
);

  //--------------------------------------------------------------
  // states and reset values
  //--------------------------------------------------------------
  localparam [1:0] S_RUN = 2'd0;
  localparam [1:0] S_HOLD = 2'd1;
  localparam [1:0] S_STAB = 2'd2;

  // reset value of each register index
  function [7:0] rst_val;
    input [5:0] ix;
    begin
      rst_val = `MRS_RV_ZERO;
      case (ix)
        `MRS_IX_FLAGS: rst_val = `MRS_RV_FLAGS;
        `MRS_IX_CLKCTL: rst_val = `MRS_RV_CLKCTL;
        `MRS_IX_STABSEL: rst_val = `MRS_RV_STABSEL;
        `MRS_IX_MEMMAP: rst_val = `MRS_RV_MEMMAP;
        `MRS_IX_TXSHIFT: rst_val = `MRS_RV_TXSHIFT;
        `MRS_IX_ADMODE: rst_val = `MRS_RV_ADMODE;
        `MRS_IX_IRQMASK: rst_val = `MRS_RV_IRQMASK;
        `MRS_IX_IRQPRIO: rst_val = `MRS_RV_IRQPRIO;
        default:
        begin
          if (ix >= `MRS_IX_DIR_BASE && ix < `MRS_IX_STATUS)
            rst_val = `MRS_RV_DIR;
          else
            rst_val = `MRS_RV_ZERO;
        end
      endcase
    end
  endfunction

  //--------------------------------------------------------------
  // reset sources and sequencing state
  //--------------------------------------------------------------
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [17:0] stab_cnt_ff;
  reg [17:0] nxt_stab_cnt;
  reg [3:0] wd_cnt_ff;
  reg [3:0] nxt_wd_cnt;
  reg from_stop_ff;
  reg nxt_from_stop;
  reg cause_wd_ff;
  reg nxt_cause_wd;
  reg [7:0] regs_ff [0:NREG-1];
  reg ack_ff;
  wire pin_low;
  wire req_any;
  wire stab_done;
  wire hold_regs;
  wire load_rv;
  wire bus_wr;
  wire [5:0] bus_ix;

  // the pin is taken as synchronous; its width is the source's duty
  // a pulse shorter than ten microseconds is still honoured
  assign pin_low = ~ext_reset_n_i;
  // both sources merge into one request
  assign req_any = pin_low | wdt_overflow_i;
  assign stab_done = (stab_cnt_ff == STAB_CYCLES[17:0] - 18'd1);
  // stop contents kept while reset is held
  assign hold_regs = from_stop_ff & (state_ff == S_HOLD);
  // post-reset values present during reset and wait, except while a reset out of stop is held
  assign load_rv = (state_ff != S_RUN) & ~hold_regs;
  assign bus_ix = wb_adr_i[7:2];
  // byte lane zero must be selected for any write
  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff & wb_sel_i[0];

  // next state of the sequencer
  always @*
  begin
    nxt_state = state_ff;
    nxt_stab_cnt = stab_cnt_ff;
    nxt_wd_cnt = wd_cnt_ff;
    nxt_from_stop = from_stop_ff;
    nxt_cause_wd = cause_wd_ff;
    case (state_ff)
      S_RUN:
      begin
        if (req_any)
        begin
          // same entry for pin and watchdog
          nxt_state = S_HOLD;
          nxt_from_stop = stop_mode_i;
          nxt_cause_wd = wdt_overflow_i & ~pin_low;
          nxt_wd_cnt = wdt_overflow_i ? `MRS_WDT_HOLD_CYCLES : 4'd0;
        end
      end
      S_HOLD:
      begin
        if (wdt_overflow_i)
          nxt_wd_cnt = `MRS_WDT_HOLD_CYCLES;
        else if (wd_cnt_ff != 4'd0)
          nxt_wd_cnt = wd_cnt_ff - 4'd1;
        // pin high releases; watchdog hold self-ends
        if (!req_any && wd_cnt_ff <= 4'd1)
        begin
          nxt_state = S_STAB;
          nxt_stab_cnt = 18'd0;
          nxt_wd_cnt = 4'd0;
        end
      end
      S_STAB:
      begin
        if (req_any)
        begin
          // a new request restarts the whole sequence
          nxt_state = S_HOLD;
          nxt_cause_wd = wdt_overflow_i & ~pin_low;
          nxt_wd_cnt = wdt_overflow_i ? `MRS_WDT_HOLD_CYCLES : 4'd0;
        end
        else if (stab_done)
        begin
          // execution begins only after the full wait
          nxt_state = S_RUN;
          nxt_from_stop = 1'b0;
        end
        else
          nxt_stab_cnt = stab_cnt_ff + 18'd1;
      end
      default:
        nxt_state = S_HOLD;
    endcase
  end

  // sequencer registers; power-on reset starts like a pin reset
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= S_HOLD;
      stab_cnt_ff <= 18'd0;
      wd_cnt_ff <= 4'd0;
      from_stop_ff <= 1'b0;
      cause_wd_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      stab_cnt_ff <= nxt_stab_cnt;
      wd_cnt_ff <= nxt_wd_cnt;
      from_stop_ff <= nxt_from_stop;
      cause_wd_ff <= nxt_cause_wd;
    end
  end

  //--------------------------------------------------------------
  // sequencer outputs
  //--------------------------------------------------------------
  // all flop outputs; reset, float, retain and run flags driven from the next state to avoid a lag
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_reset_o <= 1'b1;
      pin_hiz_o <= 1'b1;
      osc_stop_o <= 1'b0;
      ram_retain_o <= 1'b0;
      cpu_run_o <= 1'b0;
      vec_addr_o <= `MRS_VEC_ADDR_LO;
      instr_pointer_o <= 16'h0000;
    end
    else
    begin
      core_reset_o <= (nxt_state != S_RUN);
      pin_hiz_o <= (nxt_state != S_RUN);
      // oscillator off while the pin is low
      osc_stop_o <= pin_low;
      ram_retain_o <= nxt_from_stop;
      cpu_run_o <= (nxt_state == S_RUN);
      // low vector byte address through the wait, high byte address in the first run cycle
      // counter parks at its end value, so qualify with the wait state
      if (state_ff == S_STAB && stab_done)
        vec_addr_o <= `MRS_VEC_ADDR_HI;
      else
        vec_addr_o <= `MRS_VEC_ADDR_LO;
      // pointer taken from the vector at the end of the wait
      if (state_ff == S_STAB && stab_done && !req_any)
        instr_pointer_o <= {vec_hi_i, vec_lo_i};
    end
  end

  //--------------------------------------------------------------
  // register file
  //--------------------------------------------------------------
  // one flop byte per index; reset values reload during any reset
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1)
    begin : g_reg
      // index of this byte at the bus width
      localparam [5:0] REG_IX = gi;
      always @(posedge clk_i)
      begin
        if (rst_i)
          regs_ff[gi] <= rst_val(REG_IX);
        else if (load_rv)
          regs_ff[gi] <= rst_val(REG_IX);
        else if (gi == `MRS_IX_STATUS)
          // status index shows live state, never written
          regs_ff[gi] <= {4'd0, pin_low, cause_wd_ff, state_ff};
        else if (bus_wr && bus_ix == REG_IX)
          regs_ff[gi] <= wb_dat_i[7:0];
      end
    end
  endgenerate

  //--------------------------------------------------------------
  // wishbone slave
  //--------------------------------------------------------------
  // one wait-free answer: ack in the cycle after the strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~ack_ff;
      // unmapped indices answer zero
      if (bus_ix < NREG[5:0])
        wb_dat_o <= {24'h00_0000, regs_ff[bus_ix]};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  //--------------------------------------------------------------
  // memory map decode
  //--------------------------------------------------------------
  // other settings keep the previous map rather than guess a size
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rom_kbytes_o <= 6'd24;
      ram_bytes_o <= 10'd512;
    end
    else
    begin
      case (regs_ff[`MRS_IX_MEMMAP])
        `MRS_MAP_LARGE:
        begin
          rom_kbytes_o <= 6'd24;
          ram_bytes_o <= 10'd512;
        end
        `MRS_MAP_SMALL:
        begin
          rom_kbytes_o <= 6'd8;
          ram_bytes_o <= 10'd256;
        end
        `MRS_MAP_MID:
        begin
          rom_kbytes_o <= 6'd16;
          ram_bytes_o <= 10'd384;
        end
        default:
        begin
          rom_kbytes_o <= rom_kbytes_o;
          ram_bytes_o <= ram_bytes_o;
        end
      endcase
    end
  end

  //--------------------------------------------------------------
  // port pins
  //--------------------------------------------------------------
  // a zero direction bit drives; any reset phase floats the pin
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp = gp + 1)
    begin : g_port
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          port_out_o[8*gp +: 8] <= 8'h00;
          port_oe_o[8*gp +: 8] <= 8'h00;
        end
        else
        begin
          port_out_o[8*gp +: 8] <= regs_ff[`MRS_IX_LATCH_BASE + gp];
          // enables off whenever reset or wait is active
          if (nxt_state != S_RUN)
            port_oe_o[8*gp +: 8] <= 8'h00;
          else
            port_oe_o[8*gp +: 8] <= ~regs_ff[`MRS_IX_DIR_BASE + gp];
        end
      end
    end
  endgenerate

endmodule // mrs_reset_seq

`default_nettype wire

// [sim/mrs_reset_sva.sv]
// checker of the reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module mrs_reset_sva #(
  parameter int STAB_CYCLES = 16,
  parameter int NPORT = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_reset_n_i,
  input wire logic wdt_overflow_i,
  input wire logic [7:0] vec_lo_i,
  input wire logic [7:0] vec_hi_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic core_reset_o,
  input wire logic pin_hiz_o,
  input wire logic osc_stop_o,
  input wire logic cpu_run_o,
  input wire logic [15:0] instr_pointer_o,
  input wire logic [5:0] rom_kbytes_o,
  input wire logic [9:0] ram_bytes_o,
  input wire logic [8*NPORT-1:0] port_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles of reset with no source active; bounds the wait
  logic [31:0] quiet_ff;
  always_ff @(posedge clk_i)
    if (rst_i || !core_reset_o || !ext_reset_n_i || wdt_overflow_i)
      quiet_ff <= 32'h0000_0000;
    else
      quiet_ff <= quiet_ff + 32'h0000_0001;
  chk_pin_entry: assert property (
    !ext_reset_n_i |=> core_reset_o && pin_hiz_o && !cpu_run_o)
    else $error("pin reset not entered");
  chk_wd_hold: assert property (
    wdt_overflow_i |=> core_reset_o [*4])
    else $error("watchdog reset not held");
  chk_osc_stop: assert property (
    1 |=> osc_stop_o == !$past(ext_reset_n_i))
    else $error("oscillator stop wrong");
  chk_hiz_undriven: assert property (
    pin_hiz_o |-> port_oe_o == '0)
    else $error("pin driven while floating");
  chk_stab_min: assert property (
    $rose(cpu_run_o) |-> quiet_ff >= STAB_CYCLES - 1)
    else $error("wait too short");
  chk_stab_max: assert property (
    quiet_ff <= STAB_CYCLES + 10)
    else $error("wait too long");
  chk_ip_load: assert property (
    $rose(cpu_run_o) |-> instr_pointer_o == {vec_hi_i, vec_lo_i})
    else $error("vector not loaded");
  chk_map_reset: assert property (
    $past(rst_i) |-> rom_kbytes_o == 6'h18 && ram_bytes_o == 10'h200)
    else $error("reset map wrong");
  chk_ack_time: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  cov_run: cover property ($rose(cpu_run_o));
  cov_wd: cover property (wdt_overflow_i);
  cov_pin: cover property ($fell(ext_reset_n_i));
endmodule // mrs_reset_sva
bind mrs_reset_seq mrs_reset_sva #(
  .STAB_CYCLES(STAB_CYCLES),
  .NPORT(NPORT)
) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i),
  .wdt_overflow_i(wdt_overflow_i), .vec_lo_i(vec_lo_i), .vec_hi_i(vec_hi_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .core_reset_o(core_reset_o), .pin_hiz_o(pin_hiz_o), .osc_stop_o(osc_stop_o),
  .cpu_run_o(cpu_run_o), .instr_pointer_o(instr_pointer_o),
  .rom_kbytes_o(rom_kbytes_o), .ram_bytes_o(ram_bytes_o), .port_oe_o(port_oe_o));
`default_nettype wire

// [sim/mrs_rst_src.sv]
// model of the external reset source and the watchdog
`timescale 1ns/1ps
`default_nettype none
module mrs_rst_src #(
  parameter int HOLD = 1000
) (
  input wire logic clk_i,
  input wire logic pin_req_i,
  input wire logic wd_req_i,
  output logic ext_reset_n_o,
  output var logic wdt_overflow_o
);
  int cnt = 0;
  always @(posedge clk_i)
    if (pin_req_i)
      cnt <= HOLD;
    else if (cnt > 0)
      cnt <= cnt - 1;
  assign ext_reset_n_o = (cnt == 0);
  // overflow is a one-cycle pulse
  initial wdt_overflow_o = 1'b0;
  always @(posedge clk_i)
    wdt_overflow_o <= wd_req_i;
endmodule // mrs_rst_src
`default_nettype wire

// [sim/test_mcu_reset_sequencer.sv]
// testbench of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module test_mcu_reset_sequencer;
  logic clk_i = 1'b0, rst_i = 1'b1, pin_req = 1'b0, wd_req = 1'b0;
  logic ext_n, wdt_ov, stop_m = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [7:0] vlo = 8'h00, vhi = 8'h00, adr = 8'h00, q;
  logic [31:0] dat = 32'h0000_0000, rdat;
  logic [3:0] sel = 4'h0;
  logic ack, core, hiz, oscs, retain, run;
  logic [15:0] vaddr, ip;
  logic [5:0] romk;
  logic [9:0] ramb;
  logic [47:0] pout, poe;
  logic [7:0] mem [0:40];
  integer seed = 32'h8890, bad_count = 0, cmp_count = 0, i, n;
  logic [7:0] mapv [0:3] = '{8'h82, 8'h64, 8'h11, 8'h46};
  logic [15:0] mapr [0:3] = '{16'h0008, 16'h0010, 16'h0010, 16'h0018};
  logic [15:0] mapm [0:3] = '{16'h0100, 16'h0180, 16'h0180, 16'h0200};
  initial forever #5 clk_i = ~clk_i;
  mrs_rst_src u_src (.clk_i(clk_i), .pin_req_i(pin_req), .wd_req_i(wd_req),
    .ext_reset_n_o(ext_n), .wdt_overflow_o(wdt_ov));
  mrs_reset_seq #(.STAB_CYCLES(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .ext_reset_n_i(ext_n), .wdt_overflow_i(wdt_ov), .stop_mode_i(stop_m),
    .vec_lo_i(vlo), .vec_hi_i(vhi), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .core_reset_o(core), .pin_hiz_o(hiz),
    .osc_stop_o(oscs), .ram_retain_o(retain), .cpu_run_o(run),
    .vec_addr_o(vaddr), .instr_pointer_o(ip), .rom_kbytes_o(romk),
    .ram_bytes_o(ramb), .port_out_o(pout), .port_oe_o(poe));
  // reset value of each register index
  function automatic logic [7:0] exp_rv(input int ix);
    case (ix)
      0: return 8'h02;
      3, 5: return 8'h04;
      7: return 8'h46;
      15: return 8'h01;
      14, 18, 19: return 8'hFF;
      default: return (ix >= 35) ? 8'hFF : 8'h00;
    endcase
  endfunction
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // one classic cycle; holds until ack is sampled
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [7:0] d, input logic [3:0] s);
    int k;
    adr <= a;
    we <= w;
    dat <= {24'h00_0000, d};
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    k = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && k < 50)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 50) bad_count++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_all(input logic use_mem);
    for (int j = 0; j <= 40; j++)
    begin
      bus(j * 4, 1'b0, 8'h00, 4'h1);
      cmp("register", use_mem ? mem[j] : exp_rv(j), q);
    end
  endtask
  task automatic wait_run();
    n = 0;
    while (run !== 1'b1 && n < 2000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) bad_count++;
  endtask
  task automatic fire(input logic wd);
    if (wd)
      wd_req <= 1'b1;
    else
      pin_req <= 1'b1;
    @(posedge clk_i);
    wd_req <= 1'b0;
    pin_req <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #400000;
    bad_count++;
    conclude();
  end
  initial
  begin
    vlo <= $random(seed);
    vhi <= $random(seed);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_run();
    cmp("ip", {vhi, vlo}, ip);
    // high vector byte address stands in the cycle run rises
    cmp("vector", 16'h0001, vaddr);
    rd_all(1'b0);
    bus(8'hA8, 1'b0, 8'h00, 4'h1);
    cmp("unmapped", 16'h0000, q);
    bus(8'h00, 1'b1, 8'h5A, 4'h0);
    bus(8'h00, 1'b0, 8'h00, 4'h1);
    cmp("nosel", 16'h0002, q);
    $display("test reset values done");
    for (i = 0; i <= 40; i++)
    begin
      mem[i] = (i == 7) ? 8'h46 : $random(seed);
      if (i != 7) bus(i * 4, 1'b1, mem[i], 4'h1);
    end
    rd_all(1'b1);
    for (i = 0; i < 6; i++)
    begin
      cmp("oe", 8'(~mem[35 + i]), poe[8 * i +: 8]);
      cmp("out", mem[29 + i], pout[8 * i +: 8]);
    end
    fire(1'b0);
    cmp("hold", 16'h000F, {run, core, hiz, oscs, poe == 48'h0});
    wait (ext_n);
    repeat (2) @(posedge clk_i);
    cmp("wait", 16'h0006, {run, core, hiz, oscs});
    wait_run();
    rd_all(1'b0);
    $display("test pin reset done");
    // programmable part; the last write restores the reset value
    for (i = 0; i < 4; i++)
    begin
      bus(8'h1C, 1'b1, mapv[i], 4'h1);
      cmp("rom", mapr[i], romk);
      cmp("ram", mapm[i], ramb);
    end
    $display("test memory map done");
    bus(8'h00, 1'b1, 8'h77, 4'h1);
    fire(1'b1);
    cmp("wd hold", 16'h0006, {run, core, hiz, oscs});
    wait_run();
    rd_all(1'b0);
    // status byte: running, watchdog was the last cause
    bus(8'hA4, 1'b0, 8'h00, 4'h1);
    cmp("status", 16'h0004, q);
    $display("test watchdog done");
    stop_m <= 1'b1;
    bus(8'h00, 1'b1, 8'h3C, 4'h1);
    fire(1'b0);
    bus(8'h00, 1'b0, 8'h00, 4'h1);
    cmp("stop keep", 16'h003C, q);
    cmp("retain", 16'h0001, retain);
    wait_run();
    stop_m <= 1'b0;
    bus(8'h00, 1'b0, 8'h00, 4'h1);
    cmp("stop flags", 16'h0002, q);
    $display("test stop reset done");
    conclude();
  end
endmodule // test_mcu_reset_sequencer
`default_nettype wire
